// ==== rxsof_line_model.sv ====
// Line-side source model: recovered clock, sliced rails and decoded data.
`timescale 1ns/1ps
module rxsof_line_model #(
  parameter int HALF = 8
) (
  // Clock and control.
  input  wire logic       ref_clk,
  input  wire logic       act_fall,
  input  wire logic [2:0] sym,
  // Line outputs.
  output logic            rclk,
  output logic            tip,
  output logic            ring,
  output logic            nrz
);
  int cnt = 0;
  initial begin
    rclk = 1'b0;
    {tip, ring, nrz} = 3'h0;
  end
  always @(posedge ref_clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      rclk <= ~rclk;
      // A new symbol leaves on the inactive edge so it is steady at the active one.
      if (rclk != act_fall) {tip, ring, nrz} <= sym;
    end
  end
endmodule : rxsof_line_model

// ==== rxsof_monitor.sv ====
// Checker of the formatter's port behaviour.
`timescale 1ns/1ps
module rxsof_monitor (
  // Clock and reset.
  input wire logic       ref_clk,
  input wire logic       rstn,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  // Line side.
  input wire logic       recovered_rx_clock,
  input wire logic       line_tip_input,
  input wire logic       line_ring_input,
  // System side.
  input wire logic       rx_single_rail_data,
  input wire logic       rx_single_rail_data_oe,
  input wire logic       rx_negative_rail,
  input wire logic       rx_negative_rail_oe,
  input wire logic       reference_rate_clock
);
  logic [7:0] cfg1_s, cfg2_s, ctrl_s, mask_s;
  logic [3:0] quiet;
  wire        fl   = cfg1_s[rxsof_pkg::CFG1_FLOAT_BIT];
  wire        pol  = cfg2_s[rxsof_pkg::CFG2_POL_BIT];
  wire        edg  = cfg2_s[rxsof_pkg::CFG2_EDGE_BIT];
  wire        pd   = ctrl_s[2];
  wire        calm = quiet > 4'h8;
  wire        run  = calm && !pd;
  // Shadow copies of the configuration and the cycles since the last write.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg1_s <= 8'h00;
      cfg2_s <= 8'h00;
      ctrl_s <= 8'h00;
      mask_s <= 8'h00;
      quiet  <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == rxsof_pkg::ADDR_CFG1) cfg1_s <= reg_wdata;
      if (reg_wr && reg_addr == rxsof_pkg::ADDR_CFG2) cfg2_s <= reg_wdata;
      if (reg_wr && reg_addr == rxsof_pkg::ADDR_CTRL) ctrl_s <= reg_wdata;
      if (reg_wr && reg_addr == rxsof_pkg::ADDR_MASK) mask_s <= reg_wdata;
      quiet <= reg_wr ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_ref_high;
    reference_rate_clock [*8];
  endsequence
  sequence s_rclk_act;
    $past(recovered_rx_clock, 4) == !edg && $past(recovered_rx_clock, 5) == edg;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  a_float_off: assert property (calm && pd && fl |-> !rx_single_rail_data_oe && !rx_negative_rail_oe)
    else $error("pins driven while floated");
  a_drive_low: assert property (calm && pd && !fl |-> rx_single_rail_data_oe && rx_negative_rail_oe
    && !rx_single_rail_data && !rx_negative_rail)
    else $error("pins not driven low in power down");
  a_pins_driven: assert property (run |-> rx_single_rail_data_oe && rx_negative_rail_oe)
    else $error("pins not driven while running");
  a_slice_follow: assert property (run && ctrl_s[1:0] == 2'h3 |-> rx_single_rail_data == ($past(line_tip_input, 3)
    ^ pol) && rx_negative_rail == ($past(line_ring_input, 3) ^ pol))
    else $error("sliced rails do not follow line");
  a_data_edge: assert property (run && !ctrl_s[1] && $changed(rx_single_rail_data) |-> s_rclk_act)
    else $error("data changed off the active edge");
  a_irq_masked: assert property (calm && mask_s == 8'h00 |-> !irq)
    else $error("interrupt with all masked");
  a_ref_rate: assert property ($rose(reference_rate_clock) |=> s_ref_high ##[1:5] !reference_rate_clock)
    else $error("reference clock high time wrong");
endmodule : rxsof_monitor

// ==== rxsof_pkg.sv ====
// Package with constants and types of the receive system-side output formatter.
package rxsof_pkg;

  // Bit positions inside the two receive configuration words.
  localparam int CFG1_FLOAT_BIT    = 6;
  localparam int CFG2_POL_BIT      = 3;
  localparam int CFG2_EDGE_BIT     = 4;
  localparam int CFG2_IND_LSB      = 5;
  localparam int CFG2_IND_MSB      = 7;

  // Reset values of the configuration words.
  localparam logic [7:0] CFG1_RST  = 8'h00;
  localparam logic [7:0] CFG2_RST  = 8'h00;

  // Register map of the local slave.
  localparam logic [3:0] ADDR_CFG1   = 4'h0;
  localparam logic [3:0] ADDR_CFG2   = 4'h1;
  localparam logic [3:0] ADDR_CTRL   = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ    = 4'h4;
  localparam logic [3:0] ADDR_MASK   = 4'h5;
  localparam logic [7:0] CTRL_RST    = 8'h00;

  // Reference rate clock figures in kHz.
  localparam int REF_CLK_KHZ     = 40000;
  localparam int T1_RATE_KHZ     = 1544;
  localparam int E1_RATE_KHZ     = 2048;

  // Phase accumulator for the reference rate clock.
  localparam int PHASE_W = 24;
  localparam logic [PHASE_W-1:0] T1_PHASE_INC =
    PHASE_W'((64'(T1_RATE_KHZ) << PHASE_W) / 64'(REF_CLK_KHZ));
  localparam logic [PHASE_W-1:0] E1_PHASE_INC =
    PHASE_W'((64'(E1_RATE_KHZ) << PHASE_W) / 64'(REF_CLK_KHZ));

  // Output formats.
  typedef enum logic [1:0] {
    FMT_SINGLE_NRZ = 2'h0,
    FMT_DUAL_NRZ   = 2'h1,
    FMT_DUAL_RZ    = 2'h2,
    FMT_DUAL_SLICE = 2'h3
  } rxsof_fmt_t;

  // Indication sources.
  typedef enum logic [2:0] {
    IND_PATTERN  = 3'h0,
    IND_AIS      = 3'h1,
    IND_EXZ      = 3'h2,
    IND_BPV      = 3'h3,
    IND_EXZ_BPV  = 3'h4,
    IND_LOS      = 3'h5,
    IND_CLOCK    = 3'h6,
    IND_XOR      = 3'h7
  } rxsof_ind_t;

  localparam logic [23:0] IND_MAP_DEFAULT = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  // Interrupt bits.
  localparam int IRQ_LOS  = 0;
  localparam int IRQ_BPV  = 1;
  localparam int IRQ_EXZ  = 2;
  localparam int IRQ_AIS  = 3;
  localparam int IRQ_W    = 4;

endpackage : rxsof_pkg

// ==== rxsof_top.sv ====
// Receive system-side output formatter of one line interface channel.
`timescale 1ns/1ps
module rxsof_top #(
  parameter logic [23:0] IND_MAP = rxsof_pkg::IND_MAP_DEFAULT
) (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Register port.
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  // Line-side inputs, asynchronous to ref_clk.
  input  wire logic       recovered_rx_clock,
  input  wire logic       line_tip_input,
  input  wire logic       line_ring_input,
  input  wire logic       decoded_nrz_data,
  input  wire logic       pattern_indication,
  input  wire logic       line_alarm_indication,
  input  wire logic       line_excess_zeros,
  input  wire logic       line_bipolar_violation,
  input  wire logic       line_signal_loss,
  // System-side outputs.
  output logic            rx_single_rail_data,
  output logic            rx_single_rail_data_oe,
  output logic            rx_negative_rail,
  output logic            rx_negative_rail_oe,
  output logic            reference_rate_clock
);

  // Reset release through two flip-flops.
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  // Two-stage synchronisers for all line-side inputs.
  localparam int NIN = 9;
  wire  [NIN-1:0] async_in = {line_signal_loss, line_bipolar_violation, line_excess_zeros,
                              line_alarm_indication, pattern_indication, decoded_nrz_data,
                              line_ring_input, line_tip_input, recovered_rx_clock};
  logic [NIN-1:0] sync_meta_r;
  logic [NIN-1:0] sync_r;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_meta_r[gi] <= 1'b0;
          sync_r[gi]      <= 1'b0;
        end else begin
          sync_meta_r[gi] <= async_in[gi];
          sync_r[gi]      <= sync_meta_r[gi];
        end
      end
    end
  endgenerate
  wire s_clk  = sync_r[0];
  wire s_tip  = sync_r[1];
  wire s_ring = sync_r[2];
  wire s_nrz  = sync_r[3];
  wire s_pat  = sync_r[4];
  wire s_ais  = sync_r[5];
  wire s_exz  = sync_r[6];
  wire s_bpv  = sync_r[7];
  wire s_los  = sync_r[8];

  // Configuration and control registers.
  logic [7:0]             receive_config_first_r;
  logic [7:0]             receive_config_second_r;
  logic [7:0]             ctrl_r;
  logic [rxsof_pkg::IRQ_W-1:0] irq_stat_r;
  logic [rxsof_pkg::IRQ_W-1:0] irq_mask_r;

  wire powerdown_output_float_select = receive_config_first_r[rxsof_pkg::CFG1_FLOAT_BIT];
  wire data_polarity_select          = receive_config_second_r[rxsof_pkg::CFG2_POL_BIT];
  wire rx_clock_edge_select          = receive_config_second_r[rxsof_pkg::CFG2_EDGE_BIT];
  wire [2:0] indication_select_field =
    receive_config_second_r[rxsof_pkg::CFG2_IND_MSB:rxsof_pkg::CFG2_IND_LSB];
  // Control word: bits 1:0 format, bit 2 power down, bit 3 single-ended, bit 4 E1 rate.
  wire [1:0] fmt_sel      = ctrl_r[1:0];
  wire       powered_down = ctrl_r[2];
  wire       single_ended = ctrl_r[3];
  wire       e1_mode      = ctrl_r[4];

  // Register writes.
  wire wr_cfg1 = reg_wr && (reg_addr == rxsof_pkg::ADDR_CFG1);
  wire wr_cfg2 = reg_wr && (reg_addr == rxsof_pkg::ADDR_CFG2);
  wire wr_ctrl = reg_wr && (reg_addr == rxsof_pkg::ADDR_CTRL);
  wire wr_irq  = reg_wr && (reg_addr == rxsof_pkg::ADDR_IRQ);
  wire wr_mask = reg_wr && (reg_addr == rxsof_pkg::ADDR_MASK);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_config_first_r  <= rxsof_pkg::CFG1_RST;
      receive_config_second_r <= rxsof_pkg::CFG2_RST;
      ctrl_r                  <= rxsof_pkg::CTRL_RST;
      irq_mask_r              <= '0;
    end else begin
      if (wr_cfg1) receive_config_first_r  <= reg_wdata;
      if (wr_cfg2) receive_config_second_r <= reg_wdata;
      if (wr_ctrl) ctrl_r                  <= reg_wdata;
      if (wr_mask) irq_mask_r              <= reg_wdata[rxsof_pkg::IRQ_W-1:0];
    end
  end

  // Active recovered clock edge detection.
  logic clk_prev_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) clk_prev_r <= 1'b0;
    else        clk_prev_r <= s_clk;
  end
  wire rise_edge   = s_clk && !clk_prev_r;
  wire fall_edge   = !s_clk && clk_prev_r;
  wire active_edge = rx_clock_edge_select ? fall_edge : rise_edge;

  // Rail slicing by line input mode.
  wire pos_pulse = single_ended ? s_tip : (s_tip && !s_ring);
  wire neg_pulse = single_ended ? 1'b0 : (s_ring && !s_tip);
  // In single-ended mode the negative rail still reports ring-side activity while tip is low.
  wire neg_rail  = single_ended ? (s_ring && !s_tip) : neg_pulse;

  // NRZ rails are held for a bit period; RZ rails follow the recovered clock phase that starts at the active edge.
  logic pos_nrz_r;
  logic neg_nrz_r;
  logic nrz_data_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_nrz_r  <= 1'b0;
      neg_nrz_r  <= 1'b0;
      nrz_data_r <= 1'b0;
    end else if (active_edge) begin
      pos_nrz_r  <= pos_pulse;
      neg_nrz_r  <= neg_rail;
      nrz_data_r <= s_nrz;
    end
  end
  wire pos_rz = pos_nrz_r && (s_clk ^ rx_clock_edge_select);
  wire neg_rz = neg_nrz_r && (s_clk ^ rx_clock_edge_select);

  // Indication source through the parameter table.
  wire [2:0] ind_code = IND_MAP[3*indication_select_field +: 3];
  logic ind_src;
  always_comb begin
    case (ind_code)
      rxsof_pkg::IND_PATTERN: ind_src = s_pat;
      rxsof_pkg::IND_AIS:     ind_src = s_ais;
      rxsof_pkg::IND_EXZ:     ind_src = s_exz;
      rxsof_pkg::IND_BPV:     ind_src = s_bpv;
      rxsof_pkg::IND_EXZ_BPV: ind_src = s_exz || s_bpv;
      rxsof_pkg::IND_LOS:     ind_src = s_los;
      rxsof_pkg::IND_CLOCK:   ind_src = s_clk;
      rxsof_pkg::IND_XOR:     ind_src = pos_pulse ^ neg_rail;
      default:                ind_src = 1'b0;
    endcase
  end
  logic ind_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)           ind_r <= 1'b0;
    else if (active_edge) ind_r <= ind_src;
  end

  // Pin selection by format, polarity and power-down state.
  logic pin1_raw;
  logic pin2_raw;
  always_comb begin
    case (fmt_sel)
      rxsof_pkg::FMT_SINGLE_NRZ: begin
        pin1_raw = nrz_data_r ^ data_polarity_select;
        pin2_raw = ind_r;
      end
      rxsof_pkg::FMT_DUAL_NRZ: begin
        pin1_raw = pos_nrz_r ^ data_polarity_select;
        pin2_raw = neg_nrz_r ^ data_polarity_select;
      end
      rxsof_pkg::FMT_DUAL_RZ: begin
        pin1_raw = pos_rz ^ data_polarity_select;
        pin2_raw = neg_rz ^ data_polarity_select;
      end
      default: begin
        pin1_raw = pos_pulse ^ data_polarity_select;
        pin2_raw = neg_rail ^ data_polarity_select;
      end
    endcase
  end
  wire pin1_nxt = powered_down ? 1'b0 : pin1_raw;
  wire pin2_nxt = powered_down ? 1'b0 : pin2_raw;
  wire oe_nxt   = !(powered_down && powerdown_output_float_select);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_single_rail_data    <= 1'b0;
      rx_negative_rail       <= 1'b0;
      rx_single_rail_data_oe <= 1'b0;
      rx_negative_rail_oe    <= 1'b0;
    end else begin
      rx_single_rail_data    <= pin1_nxt;
      rx_negative_rail       <= pin2_nxt;
      rx_single_rail_data_oe <= oe_nxt;
      rx_negative_rail_oe    <= oe_nxt;
    end
  end

  // Reference rate clock from a phase accumulator.
  logic [rxsof_pkg::PHASE_W-1:0] phase_r;
  wire  [rxsof_pkg::PHASE_W-1:0] phase_inc = e1_mode ? rxsof_pkg::E1_PHASE_INC : rxsof_pkg::T1_PHASE_INC;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r              <= '0;
      reference_rate_clock <= 1'b0;
    end else begin
      phase_r              <= phase_r + phase_inc;
      reference_rate_clock <= phase_r[rxsof_pkg::PHASE_W-1];
    end
  end

  // Sticky event status; a set in the clearing cycle wins.
  logic [rxsof_pkg::IRQ_W-1:0] ev_prev_r;
  wire  [rxsof_pkg::IRQ_W-1:0] ev_now  = {s_ais, s_exz, s_bpv, s_los};
  wire  [rxsof_pkg::IRQ_W-1:0] ev_rise = ev_now & ~ev_prev_r;
  wire  [rxsof_pkg::IRQ_W-1:0] clr     = wr_irq ? reg_wdata[rxsof_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_r  <= '0;
      irq_stat_r <= '0;
      irq        <= 1'b0;
    end else begin
      ev_prev_r  <= ev_now;
      irq_stat_r <= (irq_stat_r & ~clr) | ev_rise;
      irq        <= |(((irq_stat_r & ~clr) | ev_rise) & irq_mask_r);
    end
  end

  // Read data, one cycle after the strobe; unmapped addresses read zero.
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      rxsof_pkg::ADDR_CFG1:   rd_mux = receive_config_first_r;
      rxsof_pkg::ADDR_CFG2:   rd_mux = receive_config_second_r;
      rxsof_pkg::ADDR_CTRL:   rd_mux = ctrl_r;
      rxsof_pkg::ADDR_STATUS: rd_mux = {3'h0, ind_r, s_los, s_bpv, s_exz, s_ais};
      rxsof_pkg::ADDR_IRQ:    rd_mux = {4'h0, irq_stat_r};
      rxsof_pkg::ADDR_MASK:   rd_mux = {4'h0, irq_mask_r};
      default:                rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)      reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else             reg_rdata <= 8'h00;
  end

endmodule : rxsof_top

// ==== tb_top.sv ====
// Self-checking bench of the receive system-side output formatter.
`timescale 1ns/1ps
module tb_top;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       irq, rclk, tip, ring, nrz, dp, dp_oe, dn, dn_oe;
  logic       act_fall = 1'b0;
  logic [2:0] sym = 3'h0;
  logic [4:0] ind = 5'h00;
  logic       rd_d = 1'b0;
  logic       smp = 1'b0;
  logic [7:0] reg_q[$];
  logic [4:0] pin_q[$];
  int         errors = 0;
  int         n_compared = 0;
  int         seed = 32'he9d9c0d9;
  always #12.5 ref_clk = ~ref_clk;
  rxsof_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .recovered_rx_clock(rclk), .line_tip_input(tip),
    .line_ring_input(ring), .decoded_nrz_data(nrz), .pattern_indication(ind[4]), .line_alarm_indication(ind[3]),
    .line_excess_zeros(ind[2]), .line_bipolar_violation(ind[1]), .line_signal_loss(ind[0]),
    .rx_single_rail_data(dp), .rx_single_rail_data_oe(dp_oe), .rx_negative_rail(dn), .rx_negative_rail_oe(dn_oe),
    .reference_rate_clock());
  rxsof_line_model i_line (.ref_clk(ref_clk), .act_fall(act_fall), .sym(sym), .rclk(rclk), .tip(tip), .ring(ring),
    .nrz(nrz));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [7:0] e);
    reg_q.push_back(e);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic pin(logic [4:0] e);
    pin_q.push_back(e);
    @(posedge ref_clk);
    smp <= 1'b1;
    @(posedge ref_clk);
    smp <= 1'b0;
  endtask : pin
  task automatic wait_rclk(logic lvl);
    for (int n = 0; rclk !== lvl; n++) begin
      if (n == 40) begin
        errors++;
        results();
      end
      @(posedge ref_clk);
    end
  endtask : wait_rclk
  // Result watcher: each result is matched to the oldest note.
  always @(posedge ref_clk) begin
    if (rd_d) check("reg_rdata", reg_q.pop_front(), reg_rdata);
    if (smp) check("irq_pins", {3'h0, pin_q.pop_front()}, {3'h0, irq, dp_oe, dp, dn_oe, dn});
    rd_d <= reg_rd;
  end
  initial begin
    logic [7:0] v;
    logic [7:0] src;
    logic [4:0] e;
    logic [3:0] adr [5];
    adr = '{4'h0, 4'h1, 4'h2, 4'h5, 4'hF};
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (adr[j]) rd(adr[j], 8'h00);
    v = 8'($random(seed));
    wr(rxsof_pkg::ADDR_CFG2, v);
    rd(rxsof_pkg::ADDR_CFG2, v);
    for (int i = 0; i < 32; i++) begin
      act_fall <= i[3];
      wr(rxsof_pkg::ADDR_CFG2, {i[4:2], i[3], i[2], 3'h0});
      wr(rxsof_pkg::ADDR_CTRL, {3'h0, i[4], i[2], 1'b0, i[1:0]});
      repeat (2) begin
        v = 8'($random(seed));
        sym <= {v[2], v[1] & ~v[2], v[0]};
        ind <= v[7:3];
        // Ring is forced low while tip is high, so the rail XOR is tip OR the ring bit.
        src = {v[2] | v[1], ~i[3], v[3], v[5] | v[4], v[4], v[5], v[6], v[7]};
        e = {2'h1, v[2] ^ i[2], 1'b1, (v[1] & ~v[2]) ^ i[2]};
        if (i[1:0] == 2'h0) e = {2'h1, v[0] ^ i[2], 1'b1, src[i[4:2]]};
        wait_rclk(~act_fall);
        wait_rclk(act_fall);
        wait_rclk(~act_fall);
        repeat (6) @(posedge ref_clk);
        pin(e);
      end
    end
    for (int f = 0; f < 2; f++) begin
      wr(rxsof_pkg::ADDR_CFG1, f ? 8'h40 : 8'h00);
      wr(rxsof_pkg::ADDR_CTRL, 8'h04);
      repeat (10) @(posedge ref_clk);
      pin(f ? 5'h00 : 5'h0A);
    end
    ind <= 5'h00;
    repeat (4) @(posedge ref_clk);
    wr(rxsof_pkg::ADDR_IRQ, 8'h0F);
    wr(rxsof_pkg::ADDR_MASK, 8'h08);
    ind <= 5'h08;
    repeat (8) @(posedge ref_clk);
    pin(5'h10);
    ind <= 5'h09;
    repeat (8) @(posedge ref_clk);
    rd(rxsof_pkg::ADDR_IRQ, 8'h09);
    wr(rxsof_pkg::ADDR_IRQ, 8'h08);
    repeat (2) @(posedge ref_clk);
    pin(5'h00);
    rd(rxsof_pkg::ADDR_IRQ, 8'h01);
    repeat (2) @(posedge ref_clk);
    results();
  end
endmodule : tb_top
bind rxsof_top rxsof_monitor i_mon (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .recovered_rx_clock(recovered_rx_clock),
  .line_tip_input(line_tip_input), .line_ring_input(line_ring_input), .rx_single_rail_data(rx_single_rail_data),
  .rx_single_rail_data_oe(rx_single_rail_data_oe), .rx_negative_rail(rx_negative_rail),
  .rx_negative_rail_oe(rx_negative_rail_oe), .reference_rate_clock(reference_rate_clock));
